/* File: verilog/eepc_ctrl.sv */
// Nonvolatile array program/erase controller with AXI4-Lite slave
// Functional notes
// R01: 8-bit control register; bits 7 and 5 read zero; resets to zero.
// R02: Charge pump runs while charge_pump_enable is set, off otherwise.
// R03: Software keeps charge_pump_enable clear when the pump is unused.
// R04: erase_select 00 program, 01 byte, 10 block, 11 bulk erase.
// R05: Byte erase touches only the addressed byte.
// R06: Block erase clears the aligned 32-byte block holding the address.
// R07: Bulk erase clears all 160 bytes on a write anywhere in array.
// R08: Latch enable blocks array reads; clear allows normal reads.
// R09: rc_clock_select times the section from the RC oscillator.
// R10: Software sets rc_clock_select when bus runs below one megahertz.
// R11: program_power_enable routes pump voltage so operation proceeds.
// R12: Program: latch, pump, erase_select 00, write data, hold power.
// R13: Byte erase: latch, pump, erase_select 01, write, hold power.
// R14: Block erase: latch, pump, erase_select 10, write in block, hold.
// R15: Bulk erase: latch, pump, erase_select 11, write anywhere, hold.
// R16: End: clear power, wait decay, then clear latch and pump.
// R17: After each operation software zeroes all control bits.
// R18: Erased cell reads one; programming only drives bits to zero.
// R19: Array spans 0100 to 019F, programmable byte by byte.
// R20: Array write while latched captures address and data.
// R21: High voltage only while power, latch and pump are all set.
`timescale 1ns/10ps
module eepc_ctrl
	import eepc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             charge_pump_on,
	output logic             high_voltage_on,
	output logic             rc_osc_select
);
	// ****************************************************************
	// Bus-side state
	// ****************************************************************
	logic [7:0]  ctrl_r, ctrl_nxt;
	logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [9:0]  waddr_r, waddr_nxt;
	logic [7:0]  wdat_r, wdat_nxt;
	logic        wstb_r, wstb_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic [7:0]  hold_addr_r, hold_addr_nxt;
	logic [7:0]  hold_data_r, hold_data_nxt;
	eepc_rd_e    rst_r, rst_nxt;
	logic [7:0]  raddr_r, raddr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;
	// ****************************************************************
	// Sequencer state
	// ****************************************************************
	eepc_seq_e   seq_r, seq_nxt;
	logic [7:0]  div_r, div_nxt, tick_cnt_r, tick_cnt_nxt;
	logic [7:0]  cur_r, cur_nxt, end_r, end_nxt;
	logic        pump_r, hv_r, rcsel_r;
	logic        mem_en, mem_we;
	logic [7:0]  mem_addr, mem_wdata, mem_rdata;
	logic        hv_req, tick, seq_idle;
	eepc_mode_e  mode;
	logic [9:0]  aw_idx, w_idx, ar_idx;
	logic        ar_is_arr, w_is_arr;
	logic [7:0]  status;

	assign mode      = eepc_mode_e'(ctrl_r[EEPC_ERH_BIT:EEPC_ERL_BIT]); // R04
	assign hv_req    = ctrl_r[EEPC_PWR_BIT] & ctrl_r[EEPC_LATCH_BIT]
	                 & ctrl_r[EEPC_PUMP_BIT]; // R21
	assign tick      = (div_r == 8'h00);
	assign seq_idle  = (seq_r == EEPC_S_IDLE);
	assign aw_idx    = s_axi_awaddr[11:2];
	assign ar_idx    = s_axi_araddr[11:2];
	assign w_idx     = waddr_r;
	assign w_is_arr  = (w_idx >= EEPC_ARR_LO_IDX) && (w_idx <= EEPC_ARR_HI_IDX);
	assign ar_is_arr = (ar_idx >= EEPC_ARR_LO_IDX)
	                 && (ar_idx <= EEPC_ARR_HI_IDX); // R19
	assign status    = {5'b00000, (seq_r == EEPC_S_DONE), ~seq_idle, hv_r};

	// ****************************************************************
	// Write channel and control register
	// ****************************************************************
	always_comb begin
		ctrl_nxt      = ctrl_r;
		aw_got_nxt    = aw_got_r;
		w_got_nxt     = w_got_r;
		waddr_nxt     = waddr_r;
		wdat_nxt      = wdat_r;
		wstb_nxt      = wstb_r;
		bvalid_nxt    = bvalid_r;
		bresp_nxt     = bresp_r;
		hold_addr_nxt = hold_addr_r;
		hold_data_nxt = hold_data_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_nxt = 1'b1;
			waddr_nxt  = aw_idx;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_nxt = 1'b1;
			wdat_nxt  = s_axi_wdata[7:0];
			wstb_nxt  = s_axi_wstrb[0];
		end
		if (aw_got_r && w_got_r) begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = EEPC_RESP_OKAY;
			if (w_idx == EEPC_CTRL_IDX) begin
				if (wstb_r) begin
					ctrl_nxt = wdat_r & EEPC_CTRL_MASK; // R01
				end
			end else if (w_idx == EEPC_STAT_IDX) begin
				bresp_nxt = EEPC_RESP_OKAY;
			end else if (w_is_arr) begin
				if (wstb_r && ctrl_r[EEPC_LATCH_BIT] && seq_idle) begin
					hold_addr_nxt = 8'(w_idx - EEPC_ARR_LO_IDX); // R20
					hold_data_nxt = wdat_r; // R20
				end
			end else begin
				bresp_nxt = EEPC_RESP_SLVERR;
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r      <= EEPC_CTRL_RST; // R01
			aw_got_r    <= 1'b0;
			w_got_r     <= 1'b0;
			waddr_r     <= 10'h000;
			wdat_r      <= 8'h00;
			wstb_r      <= 1'b0;
			bvalid_r    <= 1'b0;
			bresp_r     <= EEPC_RESP_OKAY;
			hold_addr_r <= 8'h00;
			hold_data_r <= EEPC_ERASED;
		end else begin
			ctrl_r      <= ctrl_nxt;
			aw_got_r    <= aw_got_nxt;
			w_got_r     <= w_got_nxt;
			waddr_r     <= waddr_nxt;
			wdat_r      <= wdat_nxt;
			wstb_r      <= wstb_nxt;
			bvalid_r    <= bvalid_nxt;
			bresp_r     <= bresp_nxt;
			hold_addr_r <= hold_addr_nxt;
			hold_data_r <= hold_data_nxt;
		end
	end

	assign s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign s_axi_wready  = ~w_got_r & ~bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	// ****************************************************************
	// Read channel
	// ****************************************************************
	always_comb begin
		rst_nxt   = rst_r;
		raddr_nxt = raddr_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		case (rst_r)
			EEPC_R_IDLE: begin
				if (s_axi_arvalid) begin
					rst_nxt   = EEPC_R_RESP;
					rresp_nxt = EEPC_RESP_OKAY;
					rdata_nxt = 32'h0000_0000;
					if (ar_idx == EEPC_CTRL_IDX) begin
						rdata_nxt = {24'h00_0000, ctrl_r}; // R01
					end else if (ar_idx == EEPC_STAT_IDX) begin
						rdata_nxt = {24'h00_0000, status};
					end else if (ar_is_arr) begin
						raddr_nxt = 8'(ar_idx - EEPC_ARR_LO_IDX);
						if (ctrl_r[EEPC_LATCH_BIT]) begin
							rresp_nxt = EEPC_RESP_SLVERR; // R08
						end else begin
							rst_nxt = EEPC_R_MEM; // R08
						end
					end else begin
						rresp_nxt = EEPC_RESP_SLVERR;
					end
				end
			end
			EEPC_R_MEM: begin
				if (seq_idle) begin
					rst_nxt = EEPC_R_DATA;
				end
			end
			EEPC_R_DATA: begin
				rdata_nxt = {24'h00_0000, mem_rdata};
				rst_nxt   = EEPC_R_RESP;
			end
			EEPC_R_RESP: begin
				if (s_axi_rready) begin
					rst_nxt = EEPC_R_IDLE;
				end
			end
			default: rst_nxt = EEPC_R_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_r   <= EEPC_R_IDLE;
			raddr_r <= 8'h00;
			rdata_r <= 32'h0000_0000;
			rresp_r <= EEPC_RESP_OKAY;
		end else begin
			rst_r   <= rst_nxt;
			raddr_r <= raddr_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign s_axi_arready = (rst_r == EEPC_R_IDLE);
	assign s_axi_rvalid  = (rst_r == EEPC_R_RESP);
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// ****************************************************************
	// Time base and program/erase sequencer
	// ****************************************************************
	always_comb begin
		seq_nxt      = seq_r;
		div_nxt      = div_r - 8'd1;
		tick_cnt_nxt = tick_cnt_r;
		cur_nxt      = cur_r;
		end_nxt      = end_r;
		if (tick) begin
			div_nxt = ctrl_r[EEPC_RC_BIT] ? EEPC_RC_DIV - 8'd1
			                              : EEPC_BUS_DIV - 8'd1; // R09
		end
		case (seq_r)
			EEPC_S_IDLE: begin
				tick_cnt_nxt = 8'h00;
				if (hv_req) begin
					seq_nxt = EEPC_S_TIME; // R11
				end
			end
			EEPC_S_TIME: begin
				if (!hv_req) begin
					seq_nxt = EEPC_S_IDLE; // R11
				end else if (tick) begin
					tick_cnt_nxt = tick_cnt_r + 8'd1;
					if (tick_cnt_r == EEPC_OP_TICKS - 8'd1) begin
						cur_nxt = hold_addr_r; // R05
						end_nxt = hold_addr_r;
						seq_nxt = EEPC_S_WR;
						if (mode == EEPC_PROGRAM) begin
							seq_nxt = EEPC_S_RD;
						end else if (mode == EEPC_BLK_ER) begin
							cur_nxt = {hold_addr_r[7:5], 5'b00000}; // R06
							end_nxt = {hold_addr_r[7:5], 5'b00000}
							        | EEPC_BLK_LAST; // R06
						end else if (mode == EEPC_BULK_ER) begin
							cur_nxt = 8'h00; // R07
							end_nxt = EEPC_LAST; // R07
						end
					end
				end
			end
			EEPC_S_RD: begin
				seq_nxt = EEPC_S_WR;
			end
			EEPC_S_WR: begin
				if (cur_r == end_r) begin
					seq_nxt = EEPC_S_DONE;
				end else begin
					cur_nxt = cur_r + 8'd1;
				end
			end
			EEPC_S_DONE: begin
				if (!hv_req) begin
					seq_nxt = EEPC_S_IDLE;
				end
			end
			default: seq_nxt = EEPC_S_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			seq_r      <= EEPC_S_IDLE;
			div_r      <= 8'h00;
			tick_cnt_r <= 8'h00;
			cur_r      <= 8'h00;
			end_r      <= 8'h00;
			pump_r     <= 1'b0;
			hv_r       <= 1'b0;
			rcsel_r    <= 1'b0;
		end else begin
			seq_r      <= seq_nxt;
			div_r      <= div_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			cur_r      <= cur_nxt;
			end_r      <= end_nxt;
			pump_r     <= ctrl_r[EEPC_PUMP_BIT]; // R02
			hv_r       <= hv_req; // R21
			rcsel_r    <= ctrl_r[EEPC_RC_BIT]; // R09
		end
	end

	// Sequencer owns the array port; bus reads only get it when idle
	always_comb begin
		mem_en    = 1'b0;
		mem_we    = 1'b0;
		mem_addr  = raddr_r;
		mem_wdata = EEPC_ERASED; // R18
		if (seq_r == EEPC_S_RD) begin
			mem_en   = 1'b1;
			mem_addr = cur_r;
		end else if (seq_r == EEPC_S_WR) begin
			mem_en   = 1'b1;
			mem_we   = 1'b1;
			mem_addr = cur_r;
			if (mode == EEPC_PROGRAM) begin
				mem_wdata = mem_rdata & hold_data_r; // R18
			end
		end else if (rst_r == EEPC_R_MEM && seq_idle) begin
			mem_en = 1'b1;
		end
	end

	eepc_array eepc_array_i (
		.clock (clock),
		.en    (mem_en),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	assign charge_pump_on  = pump_r;
	assign high_voltage_on = hv_r;
	assign rc_osc_select   = rcsel_r;
endmodule

/* File: verilog/eepc_pkg.sv */
// Constants and types shared by the nonvolatile program/erase controller
package eepc_pkg;
	// ****************************************************************
	// Register map (index; byte address is four times the index)
	// ****************************************************************
	localparam logic [9:0]  EEPC_CTRL_IDX    = 10'h01C;
	localparam logic [9:0]  EEPC_STAT_IDX    = 10'h01E;
	localparam logic [9:0]  EEPC_ARR_LO_IDX  = 10'h100;
	localparam logic [9:0]  EEPC_ARR_HI_IDX  = 10'h19F;
	localparam logic [7:0]  EEPC_CTRL_RST    = 8'h00;
	localparam logic [7:0]  EEPC_CTRL_MASK   = 8'h5F;
	localparam logic [7:0]  EEPC_ERASED      = 8'hFF;
	// ****************************************************************
	// Control field positions
	// ****************************************************************
	localparam int          EEPC_PUMP_BIT    = 6;
	localparam int          EEPC_ERH_BIT     = 4;
	localparam int          EEPC_ERL_BIT     = 3;
	localparam int          EEPC_LATCH_BIT   = 2;
	localparam int          EEPC_RC_BIT      = 1;
	localparam int          EEPC_PWR_BIT     = 0;
	// ****************************************************************
	// Array geometry and time base
	// ****************************************************************
	localparam int          EEPC_DEPTH       = 160;
	localparam logic [7:0]  EEPC_LAST        = 8'd159;
	localparam logic [7:0]  EEPC_BLK_LAST    = 8'd31;
	localparam logic [7:0]  EEPC_BUS_DIV     = 8'd25;
	localparam logic [7:0]  EEPC_RC_DIV      = 8'd20;
	localparam logic [7:0]  EEPC_OP_TICKS    = 8'd10;
	localparam logic [1:0]  EEPC_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  EEPC_RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		EEPC_PROGRAM = 2'b00,
		EEPC_BYTE_ER = 2'b01,
		EEPC_BLK_ER  = 2'b10,
		EEPC_BULK_ER = 2'b11
	} eepc_mode_e;
	typedef enum logic [2:0] {
		EEPC_S_IDLE = 3'b000,
		EEPC_S_TIME = 3'b001,
		EEPC_S_RD   = 3'b010,
		EEPC_S_WR   = 3'b011,
		EEPC_S_DONE = 3'b100
	} eepc_seq_e;
	typedef enum logic [1:0] {
		EEPC_R_IDLE = 2'b00,
		EEPC_R_MEM  = 2'b01,
		EEPC_R_DATA = 2'b10,
		EEPC_R_RESP = 2'b11
	} eepc_rd_e;
endpackage

/* File: verilog/eepc_array.sv */
// Byte-wide nonvolatile cell array model with registered read data
`timescale 1ns/10ps
module eepc_array
	import eepc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       en,
	input  wire logic       we,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata
);
	logic [7:0] cells [0:EEPC_DEPTH-1];

	always_ff @(posedge clock) begin
		if (en) begin
			if (we) begin
				cells[addr] <= wdata;
			end
			rdata <= cells[addr];
		end
	end
endmodule

/* File: verification/eepc_ctrl_sva.sv */
// Port assertions for the program/erase controller
`timescale 1ns/10ps
module eepc_ctrl_sva
	import eepc_pkg::*;
(
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        charge_pump_on,
	input wire logic        high_voltage_on,
	input wire logic        rc_osc_select
);
	// ****************************************************************
	// Capture of the last control write
	// ****************************************************************
	logic       ctl_wr;
	logic [7:0] ctl_r;
	logic [7:0] ctl_nxt;
	assign ctl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready && s_axi_wstrb[0] &&
		s_axi_awaddr == {EEPC_CTRL_IDX, 2'b00};
	always_comb begin
		ctl_nxt = ctl_r;
		if (ctl_wr)
			ctl_nxt = s_axi_wdata[7:0];
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			ctl_r <= 8'h00;
		else
			ctl_r <= ctl_nxt;
	end
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence ctl_take;
		ctl_wr;
	endsequence
	sequence ctl_seen;
		charge_pump_on == ctl_r[6] && rc_osc_select == ctl_r[1];
	endsequence
	AST_CTRL_OUT:
		assert property (ctl_take |=> ##[0:2] ctl_seen)
		else $error("control outputs do not follow the write");
	AST_HV_ON:
		assert property (ctl_take ##1 (ctl_r[0] && ctl_r[2] && ctl_r[6])
			|-> ##[0:2] high_voltage_on)
		else $error("high voltage missing with all enables set");
	AST_HV_GATE:
		assert property (high_voltage_on |-> charge_pump_on)
		else $error("high voltage without charge pump");
	AST_PUMP_OFF:
		assert property (ctl_take ##1 !ctl_r[6]
			|-> ##[0:2] (!charge_pump_on && !high_voltage_on))
		else $error("pump still on after clear");
	AST_R_ERRZERO:
		assert property (s_axi_rvalid && s_axi_rresp == EEPC_RESP_SLVERR
			|-> s_axi_rdata == 32'h0000_0000)
		else $error("error read carries data");
	AST_R_BYTE:
		assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	AST_R_ONE:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	AST_B_ONE:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	AST_W_BLOCK:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
endmodule

bind eepc_ctrl eepc_ctrl_sva eepc_ctrl_sva_i (.clock(clock),
	.reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.charge_pump_on(charge_pump_on), .high_voltage_on(high_voltage_on),
	.rc_osc_select(rc_osc_select));

/* File: verification/eepc_ctrl_tb.sv */
// Self-checking bench for the program/erase controller
`timescale 1ns/10ps
module eepc_ctrl_tb
	import eepc_pkg::*;
;
	localparam logic [11:0] CT = {EEPC_CTRL_IDX, 2'b00};
	localparam logic [11:0] ST = {EEPC_STAT_IDX, 2'b00};
	typedef struct {
		logic [11:0] a;
		logic [7:0]  wd;
		logic [7:0]  rd;
		logic [1:0]  rs;
		logic        hv;
	} eepc_row_s;
	logic        clock, reset_n, s_axi_awvalid, s_axi_awready;
	logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        charge_pump_on, high_voltage_on, rc_osc_select;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          failures, check_count;
	eepc_row_s   rows[9];

	eepc_ctrl eepc_ctrl_i (.clock(clock), .reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .charge_pump_on(charge_pump_on),
		.high_voltage_on(high_voltage_on), .rc_osc_select(rc_osc_select));

	always #20 clock = ~clock;
	// ****************************************************************
	// Bus and check tasks
	// ****************************************************************
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] v);
		logic got;
		got = 1'b0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!got) begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				got = 1'b1;
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
	endtask
	task rd(input logic [11:0] a);
		logic got;
		got = 1'b0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!got) begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				got = 1'b1;
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
	endtask
	function automatic logic [11:0] aa(input int b);
		return {EEPC_ARR_LO_IDX + 10'(b), 2'b00};
	endfunction
	task ck(input int b, input logic [7:0] e);
		rd(aa(b));
		chk(d, {24'h00_0000, e});
	endtask
	task op(input logic [1:0] m, input int b, input logic [7:0] v,
		input logic rc);
		wr(CT, {3'b010, m, 1'b1, rc, 1'b0});
		wr(aa(b), v);
		wr(CT, {3'b010, m, 1'b1, rc, 1'b1});
		d = '0;
		while (d[2] !== 1'b1)
			rd(ST);
		chk(d, 32'h0000_0007);
		chk(high_voltage_on, 1'b1);
		wr(CT, {3'b010, m, 1'b1, rc, 1'b0});
		wr(CT, 8'h00);
	endtask
	task results;
		$display("failures=%0d checks=%0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{clock, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'h1;
		failures = 0;
		check_count = 0;
		rows = '{'{CT, 8'hFF, 8'h5F, EEPC_RESP_OKAY, 1'b1},
			'{CT, 8'h05, 8'h05, EEPC_RESP_OKAY, 1'b0},
			'{CT, 8'h41, 8'h41, EEPC_RESP_OKAY, 1'b0},
			'{CT, 8'h18, 8'h18, EEPC_RESP_OKAY, 1'b0},
			'{CT, 8'h02, 8'h02, EEPC_RESP_OKAY, 1'b0},
			'{CT, 8'hA0, 8'h00, EEPC_RESP_OKAY, 1'b0},
			'{12'h004, 8'h12, 8'h00, EEPC_RESP_SLVERR, 1'b0},
			'{12'h680, 8'h12, 8'h00, EEPC_RESP_SLVERR, 1'b0},
			'{ST, 8'hFF, 8'h00, EEPC_RESP_OKAY, 1'b0}};
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].wd);
			chk(r, rows[i].rs);
			rd(rows[i].a);
			chk(d, rows[i].rd);
			chk(r, rows[i].rs);
			chk(high_voltage_on, rows[i].hv);
			chk(charge_pump_on, rows[i].rd[6]);
			chk(rc_osc_select, rows[i].rd[1]);
		end
		$display("test table done");
		wr(CT, 8'h46);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd(CT);
		chk(d, 32'h0000_0000);
		chk(charge_pump_on, 1'b0);
		$display("test reset done");
		op(2'h3, 159, 8'h00, 1'b0);
		ck(0, 8'hFF);
		ck(159, 8'hFF);
		op(2'h0, 33, 8'hA5, 1'b1);
		ck(33, 8'hA5);
		op(2'h0, 33, 8'h0F, 1'b0);
		ck(33, 8'h05);
		op(2'h0, 34, 8'h00, 1'b0);
		op(2'h0, 31, 8'h00, 1'b0);
		op(2'h0, 64, 8'h00, 1'b0);
		op(2'h1, 33, 8'h00, 1'b0);
		ck(33, 8'hFF);
		ck(34, 8'h00);
		op(2'h2, 63, 8'h00, 1'b0);
		ck(34, 8'hFF);
		ck(31, 8'h00);
		ck(64, 8'h00);
		$display("test modes done");
		wr(CT, 8'h04);
		rd(aa(0));
		chk(r, EEPC_RESP_SLVERR);
		wr(CT, 8'h00);
		ck(0, 8'hFF);
		wr(CT, 8'h44);
		wr(aa(0), 8'h00);
		wr(CT, 8'h45);
		wr(CT, 8'h44);
		wr(CT, 8'h00);
		ck(0, 8'hFF);
		s_axi_wstrb <= 4'h0;
		wr(CT, 8'h40);
		s_axi_wstrb <= 4'h1;
		rd(CT);
		chk(d, 32'h0000_0000);
		$display("test latch and abort done");
		results;
	end
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		results;
	end
endmodule
